//--- avt_proc.v
// Stereo volume, balance, fade, soft mute, tone, de-emphasis and output scaling
// Assumes control ports come from a register file on i_sys_clk and that samples
// arrive from same-clock logic once per audio sample period.
// Functional notes
// RULE1: Each channel balance code 15 is 0 dB, each lower code 1.5 dB less.
// RULE2: Balance plus volume never attenuates beyond the lowest volume step.
// RULE3: With fade-run low, volume and fade-time changes leave the gain unchanged.
// RULE4: With fade-run high, gain moves alone toward the target volume.
// RULE5: Volume step is 0.375 dB; normal +6 to -90 dB, double 0 to -96 dB.
// RULE6: Fade length depends only on the fade-time code, not step size.
// RULE7: Double-speed mode applies a new volume at the next sample, no fade.
// RULE8: Volume is an 8-bit code; code zero silences the output fully.
// RULE9: Normal speed gain is (code minus 239) volume steps.
// RULE10: Double speed gain is (code minus 255) volume steps.
// RULE11: A full fade lasts (FT+1)*(16FT+1)*256 sample periods.
// RULE12: Mute high ramps to zero on a 32-entry cosine, 32 samples each.
// RULE13: Mute low ramps back up through the same cosine in reverse.
// RULE14: Mute coefficient changes only between whole samples.
// RULE15: Scale field 00 -0.9, 01 +0.9, 10 -0.66, 11 -0.99.
// RULE16: Scale low bit zero by default gives an inverting output.
// RULE17: The controller should avoid the two scale codes with upper bit set.
// RULE18: De-emphasis field 00 off, 01 32 kHz, 10 44.1 kHz, 11 48 kHz.
// RULE19: Treble is a first-order shelf at 2.1 kHz, -10.5 to +12 dB.
// RULE20: Treble flat position passes samples unchanged.
// RULE21: Bass is a first-order shelf at 500 Hz chosen by 4-bit code.
// RULE22: Bass flat position passes samples unchanged.
// RULE23: The controller should offset strong tone boost with volume cut.
// RULE24: Treble code 7 and bass code 6 are flat, 1.5 dB per step.
// RULE25: Double-speed bit selects the double-speed volume scale, no fading.
// RULE26: Order is de-emphasis, tone, volume with balance, mute, scaling.
// RULE27: A new target during a running fade continues from the current gain.
`timescale 1ns/1ps
`include "avt_map.vh"

// ----------------------------------------
// Output FIFO
// ----------------------------------------
module avt_fifo #(
  parameter W = 36,
  parameter D = 8,
  parameter AW = 3
) (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [W-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [W-1:0] o_out_data
);
  localparam [AW:0] CNT_FULL = D;
  reg [W-1:0] mem_ff [0:D-1];
  reg [AW-1:0] wr_ff;
  reg [AW-1:0] rd_ff;
  reg [AW:0] cnt_ff;
  wire push;
  wire pop;

  assign o_in_ready = (cnt_ff != CNT_FULL);
  assign o_out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = mem_ff[rd_ff];

  always @(posedge i_sys_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end

  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ff <= {AW{1'b0}};
      rd_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------
// Processor top
// ----------------------------------------
module avt_proc #(
  parameter FADE_SHIFT = `AVT_FADE_SHIFT
) (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [17:0] i_in_left,
  input wire [17:0] i_in_right,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [17:0] o_out_left,
  output wire [17:0] o_out_right,
  input wire [3:0] i_left_balance_code,
  input wire [3:0] i_right_balance_code,
  input wire [7:0] i_volume_code,
  input wire [3:0] i_fade_time_code,
  input wire i_fade_run_flag,
  input wire i_mute_enable,
  input wire i_output_scale_high_bit,
  input wire i_output_scale_low_bit,
  input wire i_deemphasis_select_high,
  input wire i_deemphasis_select_low,
  input wire [3:0] i_treble_tone_code,
  input wire [3:0] i_bass_tone_code,
  input wire i_double_speed_enable,
  output wire o_fade_busy,
  output wire [7:0] o_applied_volume,
  output wire [5:0] o_mute_level
);
  localparam [15:0] FADE_LAST = {16{1'b1}} >> (16 - FADE_SHIFT);

  // ----------------------------------------
  // Lookup and saturation functions
  // ----------------------------------------
  function [15:0] mant16;
    input [3:0] k;
    begin
      case (k)
        4'h0: mant16 = 16'h8000;
        4'h1: mant16 = 16'h85AB;
        4'h2: mant16 = 16'h8B96;
        4'h3: mant16 = 16'h91C4;
        4'h4: mant16 = 16'h9838;
        4'h5: mant16 = 16'h9EF5;
        4'h6: mant16 = 16'hA5FF;
        4'h7: mant16 = 16'hAD58;
        4'h8: mant16 = 16'hB505;
        4'h9: mant16 = 16'hBD09;
        4'hA: mant16 = 16'hC567;
        4'hB: mant16 = 16'hCE24;
        4'hC: mant16 = 16'hD745;
        4'hD: mant16 = 16'hE0CD;
        4'hE: mant16 = 16'hEAC1;
        default: mant16 = 16'hF525;
      endcase
    end
  endfunction

  // Cosine ramp from unity (level 0) to zero (level 32)
  function [15:0] mute_coef;
    input [5:0] lvl;
    begin
      case (lvl)
        6'h00: mute_coef = 16'h8000;
        6'h01: mute_coef = 16'h7FB1;
        6'h02: mute_coef = 16'h7EC5;
        6'h03: mute_coef = 16'h7D3E;
        6'h04: mute_coef = 16'h7B21;
        6'h05: mute_coef = 16'h7871;
        6'h06: mute_coef = 16'h7537;
        6'h07: mute_coef = 16'h7179;
        6'h08: mute_coef = 16'h6D41;
        6'h09: mute_coef = 16'h689A;
        6'h0A: mute_coef = 16'h638E;
        6'h0B: mute_coef = 16'h5E2B;
        6'h0C: mute_coef = 16'h587E;
        6'h0D: mute_coef = 16'h5294;
        6'h0E: mute_coef = 16'h4C7C;
        6'h0F: mute_coef = 16'h4646;
        6'h10: mute_coef = 16'h4000;
        6'h11: mute_coef = 16'h39BA;
        6'h12: mute_coef = 16'h3384;
        6'h13: mute_coef = 16'h2D6C;
        6'h14: mute_coef = 16'h2782;
        6'h15: mute_coef = 16'h21D5;
        6'h16: mute_coef = 16'h1C72;
        6'h17: mute_coef = 16'h1766;
        6'h18: mute_coef = 16'h12BF;
        6'h19: mute_coef = 16'h0E87;
        6'h1A: mute_coef = 16'h0AC9;
        6'h1B: mute_coef = 16'h078F;
        6'h1C: mute_coef = 16'h04DF;
        6'h1D: mute_coef = 16'h02C2;
        6'h1E: mute_coef = 16'h013B;
        6'h1F: mute_coef = 16'h004F;
        default: mute_coef = 16'h0000;
      endcase
    end
  endfunction

  // Shelf gain minus one in Q12, index 0 is -10.5 dB, 1.5 dB per step
  function signed [15:0] tone_gm1;
    input [4:0] idx;
    begin
      case (idx)
        5'h00: tone_gm1 = 16'shF4C7;
        5'h01: tone_gm1 = 16'shF5AD;
        5'h02: tone_gm1 = 16'shF6BF;
        5'h03: tone_gm1 = 16'shF805;
        5'h04: tone_gm1 = 16'shF988;
        5'h05: tone_gm1 = 16'shFB54;
        5'h06: tone_gm1 = 16'shFD76;
        5'h07: tone_gm1 = 16'sh0000;
        5'h08: tone_gm1 = 16'sh0304;
        5'h09: tone_gm1 = 16'sh069A;
        5'h0A: tone_gm1 = 16'sh0ADC;
        5'h0B: tone_gm1 = 16'sh0FED;
        5'h0C: tone_gm1 = 16'sh15F1;
        5'h0D: tone_gm1 = 16'sh1D18;
        5'h0E: tone_gm1 = 16'sh2598;
        5'h0F: tone_gm1 = 16'sh2FB3;
        default: tone_gm1 = 16'sh3BB4;
      endcase
    end
  endfunction

  function signed [17:0] sat18;
    input signed [39:0] v;
    begin
      if ((&v[39:17]) || !(|v[39:17])) begin
        sat18 = v[17:0];
      end else begin
        sat18 = v[39] ? 18'h2_0000 : 18'h1_FFFF;
      end
    end
  endfunction

  // ----------------------------------------
  // Control decode
  // ----------------------------------------
  wire fifo_ready;
  wire tick;
  wire [35:0] proc_data;
  wire [35:0] fifo_data;
  wire [1:0] dem_sel;
  wire [4:0] trb_idx;
  wire [4:0] bass_idx;
  wire trb_flat;
  wire bass_flat;
  wire [8:0] vol_ofs;
  wire [11:0] fade_len;
  wire [23:0] fade_mul;
  wire [24:0] fade_diff;
  reg signed [15:0] dem_b0;
  reg signed [15:0] dem_b1;
  reg signed [15:0] dem_a;
  reg signed [15:0] scl;
  reg [23:0] cur_ff;
  reg [7:0] tgt_ff;
  reg signed [24:0] step_ff;
  reg fading_ff;
  reg [11:0] scnt_ff;
  reg [15:0] fcnt_ff;
  reg [5:0] lvl_ff;
  reg [4:0] mcnt_ff;

  assign tick = i_in_valid & fifo_ready;
  assign o_in_ready = fifo_ready;
  assign dem_sel = {i_deemphasis_select_high, i_deemphasis_select_low};
  assign trb_idx = {1'b0, i_treble_tone_code};
  assign bass_idx = {1'b0, i_bass_tone_code} + `AVT_BASS_OFS; // RULE24
  assign trb_flat = i_double_speed_enable || (trb_idx == `AVT_TONE_FLAT); // RULE20
  assign bass_flat = i_double_speed_enable || (bass_idx == `AVT_TONE_FLAT); // RULE22
  assign vol_ofs = i_double_speed_enable ? `AVT_DS_OFS : `AVT_NS_OFS; // RULE5 RULE25
  assign fade_mul = ({8'h00, i_fade_time_code} + 12'h001) *
                    (({8'h00, i_fade_time_code} << `AVT_FT_MUL) + 12'h001);
  assign fade_len = fade_mul[11:0]; // RULE11
  assign fade_diff = {1'b0, i_volume_code, 16'h0000} - {1'b0, cur_ff};
  assign o_fade_busy = fading_ff;
  assign o_applied_volume = cur_ff[23:16];
  assign o_mute_level = lvl_ff;

  always @* begin
    case (dem_sel) // RULE18
      2'h1: begin
        dem_b0 = `AVT_DEM32_B0;
        dem_b1 = `AVT_DEM32_B1;
        dem_a = `AVT_DEM32_A;
      end
      2'h2: begin
        dem_b0 = `AVT_DEM44_B0;
        dem_b1 = `AVT_DEM44_B1;
        dem_a = `AVT_DEM44_A;
      end
      default: begin
        dem_b0 = `AVT_DEM48_B0;
        dem_b1 = `AVT_DEM48_B1;
        dem_a = `AVT_DEM48_A;
      end
    endcase
    case ({i_output_scale_high_bit, i_output_scale_low_bit}) // RULE15
      2'h0: scl = `AVT_SCL_INV09; // RULE16
      2'h1: scl = `AVT_SCL_POS09;
      2'h2: scl = `AVT_SCL_INV066;
      default: scl = `AVT_SCL_INV099;
    endcase
  end

  // ----------------------------------------
  // Volume fade engine
  // ----------------------------------------
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cur_ff <= {`AVT_VOL_RST, 16'h0000};
      tgt_ff <= `AVT_VOL_RST;
      step_ff <= 25'h000_0000;
      fading_ff <= 1'b0;
      scnt_ff <= 12'h000;
      fcnt_ff <= 16'h0000;
    end else if (i_double_speed_enable) begin
      fading_ff <= 1'b0;
      if (tick && i_fade_run_flag) begin
        cur_ff <= {i_volume_code, 16'h0000}; // RULE7
        tgt_ff <= i_volume_code;
      end
    end else if (i_fade_run_flag) begin // RULE3
      if ((i_volume_code != tgt_ff) ||
          (!fading_ff && (cur_ff != {i_volume_code, 16'h0000}))) begin
        // Restart from the gain now applied
        tgt_ff <= i_volume_code; // RULE27
        step_ff <= $signed(fade_diff) >>> FADE_SHIFT; // RULE4 RULE6
        fading_ff <= 1'b1;
        scnt_ff <= 12'h000;
        fcnt_ff <= 16'h0000;
      end else if (fading_ff && tick) begin
        if (scnt_ff == fade_len - 12'h001) begin // RULE11
          scnt_ff <= 12'h000;
          fcnt_ff <= fcnt_ff + 16'h0001;
          if (fcnt_ff == FADE_LAST) begin
            cur_ff <= {tgt_ff, 16'h0000};
            fading_ff <= 1'b0;
          end else begin
            cur_ff <= cur_ff + step_ff[23:0]; // RULE4
          end
        end else begin
          scnt_ff <= scnt_ff + 12'h001;
        end
      end
    end
  end

  // ----------------------------------------
  // Soft mute ramp
  // ----------------------------------------
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lvl_ff <= 6'h00;
      mcnt_ff <= 5'h00;
    end else if (tick) begin // RULE14
      if ((i_mute_enable && lvl_ff != `AVT_MUTE_FULL) || (!i_mute_enable && lvl_ff != 6'h00)) begin
        mcnt_ff <= mcnt_ff + 5'h01;
        if (mcnt_ff == `AVT_MUTE_LAST_SMP) begin // RULE12
          lvl_ff <= i_mute_enable ? lvl_ff + 6'h01 : lvl_ff - 6'h01; // RULE13
        end
      end else begin
        mcnt_ff <= 5'h00;
      end
    end
  end

  // ----------------------------------------
  // Per-channel sample path
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      reg signed [17:0] dx_ff;
      reg signed [17:0] dy_ff;
      reg signed [17:0] blp_ff;
      reg signed [17:0] tlp_ff;
      reg signed [17:0] x;
      reg signed [17:0] d;
      reg signed [17:0] blp;
      reg signed [17:0] b;
      reg signed [17:0] tlp;
      reg signed [17:0] hp;
      reg signed [17:0] t;
      reg signed [17:0] v;
      reg signed [17:0] m;
      reg signed [17:0] s;
      reg signed [39:0] acc;
      reg [3:0] bal;
      reg [8:0] att;
      reg [8:0] e;
      reg [8:0] y;

      always @* begin
        x = (ch == 1) ? i_in_right : i_in_left;
        bal = (ch == 1) ? i_right_balance_code : i_left_balance_code;
        acc = dem_b0 * x + dem_b1 * dx_ff + dem_a * dy_ff;
        d = (dem_sel == 2'h0) ? x : sat18(acc >>> 14); // RULE18 RULE26
        acc = `AVT_BASS_ALPHA * (d - blp_ff);
        blp = sat18(blp_ff + (acc >>> 14)); // RULE21
        acc = tone_gm1(bass_idx) * blp;
        b = bass_flat ? d : sat18(d + (acc >>> 12)); // RULE21
        acc = `AVT_TRB_ALPHA * (b - tlp_ff);
        tlp = sat18(tlp_ff + (acc >>> 14)); // RULE19
        hp = sat18(b - tlp);
        acc = tone_gm1(trb_idx) * hp;
        t = trb_flat ? b : sat18(b + (acc >>> 12)); // RULE19 RULE24
        att = {3'h0, `AVT_BAL_FULL - bal, 2'h0}; // RULE1
        e = ({1'b0, cur_ff[23:16]} > att) ? {1'b0, cur_ff[23:16]} - att : `AVT_VOL_MIN; // RULE2
        y = e + vol_ofs; // RULE9 RULE10
        acc = t * $signed({1'b0, mant16(y[3:0])});
        v = (cur_ff[23:16] == 8'h00) ? 18'h0_0000 : sat18(acc >>> (5'h1F - y[8:4])); // RULE8
        acc = v * $signed({1'b0, mute_coef(lvl_ff)});
        m = sat18(acc >>> 15); // RULE12
        acc = m * scl;
        s = sat18(acc >>> 15); // RULE15 RULE26
      end

      always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          dx_ff <= 18'h0_0000;
          dy_ff <= 18'h0_0000;
          blp_ff <= 18'h0_0000;
          tlp_ff <= 18'h0_0000;
        end else if (tick) begin
          dx_ff <= x;
          dy_ff <= d;
          blp_ff <= blp;
          tlp_ff <= tlp;
        end
      end

      assign proc_data[ch*18 +: 18] = s;
    end
  endgenerate

  // ----------------------------------------
  // Output buffer
  // ----------------------------------------
  avt_fifo #(
    .W(36),
    .D(`AVT_FIFO_DEPTH),
    .AW(`AVT_FIFO_AW)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(i_in_valid),
    .o_in_ready(fifo_ready),
    .i_in_data(proc_data),
    .o_out_valid(o_out_valid),
    .i_out_ready(i_out_ready),
    .o_out_data(fifo_data)
  );

  assign o_out_left = fifo_data[17:0];
  assign o_out_right = fifo_data[35:18];
endmodule

//--- avt_map.vh
// Constants for the stereo volume, tone and mute processor
// Assumes Q14 filter coefficients, Q15 gains and 18-bit samples
`ifndef AVT_MAP_VH
`define AVT_MAP_VH

// ----------------------------------------
// Sample and stream
// ----------------------------------------
`define AVT_W 18
`define AVT_FIFO_DEPTH 8
`define AVT_FIFO_AW 3

// ----------------------------------------
// Volume and fade
// ----------------------------------------
`define AVT_VOL_RST 8'hEF
`define AVT_NS_OFS 9'h011
`define AVT_DS_OFS 9'h001
`define AVT_VOL_MIN 9'h001
`define AVT_BAL_FULL 4'hF
`define AVT_FADE_SHIFT 8
`define AVT_FT_MUL 4

// ----------------------------------------
// Soft mute
// ----------------------------------------
`define AVT_MUTE_LAST_SMP 5'h1F
`define AVT_MUTE_FULL 6'h20

// ----------------------------------------
// Tone and de-emphasis
// ----------------------------------------
`define AVT_TONE_FLAT 5'h07
`define AVT_BASS_OFS 5'h01
`define AVT_TRB_ALPHA 16'sh108D
`define AVT_BASS_ALPHA 16'sh0467
`define AVT_DEM32_B0 16'sh21F9
`define AVT_DEM32_B1 16'shFBC5
`define AVT_DEM32_A 16'sh2242
`define AVT_DEM44_B0 16'sh1DEF
`define AVT_DEM44_B1 16'shF967
`define AVT_DEM44_A 16'sh28AA
`define AVT_DEM48_B0 16'sh1D0E
`define AVT_DEM48_B1 16'shF8C1
`define AVT_DEM48_A 16'sh2A30

// ----------------------------------------
// Output scaling
// ----------------------------------------
`define AVT_SCL_INV09 16'sh8CCD
`define AVT_SCL_POS09 16'sh7333
`define AVT_SCL_INV066 16'shAB85
`define AVT_SCL_INV099 16'sh8148

`endif

//--- avt_proc_monitor.sv
// Port checker for the stereo volume, tone and mute processor
// Assumes it is bound onto avt_proc and that all ports share i_sys_clk
`timescale 1ns/1ps
module avt_proc_monitor (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_in_valid,
  input wire o_in_ready,
  input wire o_out_valid,
  input wire i_out_ready,
  input wire [17:0] o_out_left,
  input wire [17:0] o_out_right,
  input wire [7:0] i_volume_code,
  input wire i_fade_run_flag,
  input wire i_mute_enable,
  input wire i_double_speed_enable,
  input wire o_fade_busy,
  input wire [7:0] o_applied_volume,
  input wire [5:0] o_mute_level
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_take;
    i_in_valid && o_in_ready;
  endsequence
  sequence s_fade_end;
    $fell(o_fade_busy) && $stable(i_volume_code);
  endsequence
  property p_full_has_data;
    !o_in_ready |-> o_out_valid;
  endproperty
  property p_out_hold;
    o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_left) && $stable(o_out_right);
  endproperty
  property p_freeze;
    !i_fade_run_flag |=> $stable(o_applied_volume);
  endproperty
  property p_busy_cause;
    $rose(o_fade_busy) |-> $past(i_fade_run_flag) && !$past(i_double_speed_enable);
  endproperty
  property p_ds_direct;
    i_double_speed_enable && i_fade_run_flag && i_in_valid && o_in_ready |=>
      !o_fade_busy && o_applied_volume == $past(i_volume_code);
  endproperty
  property p_mute_step;
    $changed(o_mute_level) |-> o_mute_level == $past(o_mute_level) + 6'h01 || o_mute_level + 6'h01 == $past(o_mute_level);
  endproperty
  property p_mute_dir;
    $changed(o_mute_level) |-> (o_mute_level > $past(o_mute_level)) == $past(i_mute_enable);
  endproperty
  property p_mute_whole;
    $changed(o_mute_level) |-> $past(i_in_valid && o_in_ready);
  endproperty
  property p_vol_whole;
    $changed(o_applied_volume) |-> $past(i_in_valid && o_in_ready);
  endproperty
  property p_fade_target;
    s_fade_end |-> o_applied_volume == i_volume_code;
  endproperty
  a_full_has_data: assert property (p_full_has_data) else $error("fifo full but no output word");
  a_out_hold: assert property (p_out_hold) else $error("output word changed before taken");
  a_freeze: assert property (p_freeze) else $error("gain moved while fade run low");
  a_busy_cause: assert property (p_busy_cause) else $error("fade started without run or in double speed");
  a_ds_direct: assert property (p_ds_direct) else $error("fade started in double speed");
  a_mute_step: assert property (p_mute_step) else $error("mute level jumped");
  a_mute_dir: assert property (p_mute_dir) else $error("mute level moved against mute bit");
  a_mute_whole: assert property (p_mute_whole) else $error("mute level changed between samples");
  a_vol_whole: assert property (p_vol_whole) else $error("gain changed between samples");
  a_fade_target: assert property (p_fade_target) else $error("fade ended off target");
  c_take: cover property (s_take ##1 s_take);
endmodule

bind avt_proc avt_proc_monitor avt_proc_monitor_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
  .i_in_valid(i_in_valid), .o_in_ready(o_in_ready), .o_out_valid(o_out_valid), .i_out_ready(i_out_ready),
  .o_out_left(o_out_left), .o_out_right(o_out_right), .i_volume_code(i_volume_code),
  .i_fade_run_flag(i_fade_run_flag), .i_mute_enable(i_mute_enable), .i_double_speed_enable(i_double_speed_enable),
  .o_fade_busy(o_fade_busy), .o_applied_volume(o_applied_volume), .o_mute_level(o_mute_level));

//--- avt_sink_model.sv
// Output sink for the processor: collects processed stereo words
// Assumes valid/ready on rising edges of i_sys_clk; can stall or take every other cycle
`timescale 1ns/1ps
module avt_sink_model (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_out_valid,
  input wire [17:0] i_out_left,
  input wire [17:0] i_out_right,
  input wire i_stall,
  input wire i_slow,
  output reg o_out_ready
);
  logic [35:0] got[$];
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_out_ready <= 1'b0;
    end else begin
      if (i_out_valid && o_out_ready) begin
        got.push_back({i_out_left, i_out_right});
      end
      o_out_ready <= !i_stall && !(i_slow && o_out_ready);
    end
  end
endmodule

//--- avt_proc_test.sv
// Self-checking bench for the stereo volume, tone and mute processor
// Assumes avt_proc with a short fade (FADE_SHIFT 2) and the sink model on its output
`timescale 1ns/1ps
module avt_proc_test;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic in_valid = 1'b0;
  logic [17:0] in_l = 18'h0_0000;
  logic [17:0] in_r = 18'h0_0000;
  logic [3:0] bl = 4'hF;
  logic [3:0] br = 4'hF;
  logic [7:0] vol = 8'hEF;
  logic [3:0] ft = 4'h0;
  logic [3:0] trb = 4'h7;
  logic [3:0] bas = 4'h6;
  logic run = 1'b0, mute = 1'b0, sh = 1'b0, sl = 1'b0, dh = 1'b0, dl = 1'b0, ds = 1'b0;
  logic stall = 1'b0, slow = 1'b0;
  wire in_ready, out_valid, out_ready, busy;
  wire [17:0] out_l, out_r;
  wire [7:0] appv;
  wire [5:0] mlev;
  logic [17:0] gl, gr;
  int err_count = 0, tests_run = 0, i, n;
  real kt[4] = '{-0.9, 0.9, -0.66, -0.99};

  always #10 i_sys_clk = ~i_sys_clk;

  avt_proc #(.FADE_SHIFT(2)) avt_proc_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_in_valid(in_valid), .o_in_ready(in_ready), .i_in_left(in_l), .i_in_right(in_r),
    .o_out_valid(out_valid), .i_out_ready(out_ready), .o_out_left(out_l), .o_out_right(out_r),
    .i_left_balance_code(bl), .i_right_balance_code(br), .i_volume_code(vol), .i_fade_time_code(ft),
    .i_fade_run_flag(run), .i_mute_enable(mute), .i_output_scale_high_bit(sh), .i_output_scale_low_bit(sl),
    .i_deemphasis_select_high(dh), .i_deemphasis_select_low(dl), .i_treble_tone_code(trb),
    .i_bass_tone_code(bas), .i_double_speed_enable(ds), .o_fade_busy(busy), .o_applied_volume(appv),
    .o_mute_level(mlev));
  avt_sink_model avt_sink_model_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_out_valid(out_valid),
    .i_out_left(out_l), .i_out_right(out_r), .i_stall(stall), .i_slow(slow), .o_out_ready(out_ready));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic int sc(input int x, input real k);
    return $rtoi(x * k);
  endfunction
  task automatic chk(input string nm, input int exp, input logic [17:0] got, input int tol);
    int d;
    begin
      tests_run++;
      d = $signed(got) - exp;
      if ($isunknown(got) || d > tol || d < -tol) begin
        err_count++;
        $display("[ERR] %s expected %0d seen %0d", nm, exp, $signed(got));
      end
    end
  endtask
  // Valid rises one edge after the call so control changes land first
  task automatic push(input int l, input int r);
    int k;
    begin
      k = 0;
      @(posedge i_sys_clk);
      #1;
      in_l = l[17:0];
      in_r = r[17:0];
      in_valid = 1'b1;
      while (in_ready !== 1'b1 && k < 500) begin
        @(posedge i_sys_clk);
        #1;
        k++;
      end
      @(posedge i_sys_clk);
      #1;
      in_valid = 1'b0;
      in_l = ~in_l;
      in_r = ~in_r;
    end
  endtask
  task automatic pull(output logic [17:0] l, output logic [17:0] r);
    int k;
    logic [35:0] w;
    begin
      k = 0;
      w = 'x;
      while (avt_sink_model_inst.got.size() == 0 && k < 100) begin
        @(posedge i_sys_clk);
        #1;
        k++;
      end
      if (avt_sink_model_inst.got.size() != 0) begin
        w = avt_sink_model_inst.got.pop_front();
      end
      {l, r} = w;
    end
  endtask
  task automatic xf(input int l, input int r);
    begin
      push(l, r);
      pull(gl, gr);
    end
  endtask
  task automatic fade(input logic [7:0] tg, input int mx, output int c);
    begin
      vol = tg;
      run = 1'b1;
      c = 0;
      do begin
        xf(4096, 4096);
        c++;
      end while (busy === 1'b1 && c < mx);
    end
  endtask
  task automatic end_of_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #(20 * 60000);
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge i_sys_clk);
    #1;
    i_reset_n = 1'b1;
    chk("in_ready", 1, {17'h0_0000, in_ready}, 0);
    chk("out_valid", 0, {17'h0_0000, out_valid}, 0);
    chk("reset_vol", 239, {10'h000, appv}, 0);
    chk("reset_mute", 0, {12'h000, mlev}, 0);
    xf(65536, -32768);
    chk("default_pol", sc(65536, -0.9), gl, 8);
    for (i = 0; i < 4; i++) begin
      {sh, sl} = i[1:0];
      xf(65536, -32768);
      chk("scale_l", sc(65536, kt[i]), gl, 8);
      chk("scale_r", sc(-32768, kt[i]), gr, 8);
    end
    {sh, sl} = 2'b01;
    br = 4'hB;
    xf(65536, 65536);
    chk("bal_l", sc(65536, 0.9), gl, 8);
    chk("bal_r", sc(65536, 0.9 * 10.0 ** (-6.0 / 20.0)), gr, 100);
    br = 4'hF;
    for (i = 0; i < 4; i++) begin
      {dh, dl} = i[1:0];
      repeat (30) xf(32768, 32768);
      chk("deemph_dc", sc(32768, 0.9), gl, 40);
    end
    {dh, dl} = 2'b00;
    bas = 4'hA;
    repeat (150) xf(16384, 16384);
    chk("bass_dc", sc(16384, 0.9 * 10.0 ** (6.0 / 20.0)), gl, 150);
    bas = 4'h6;
    trb = 4'hF;
    repeat (40) xf(16384, 16384);
    chk("treble_dc", sc(16384, 0.9), gl, 40);
    trb = 4'h7;
    stall = 1'b1;
    for (i = 0; i < 8; i++) push(i * 4096, 0);
    chk("full_ready", 0, {17'h0_0000, in_ready}, 0);
    fork
      push(32768, 0);
      begin
        repeat (20) @(posedge i_sys_clk);
        #1;
        chk("refused", 0, {17'h0_0000, in_ready}, 0);
        slow = 1'b1;
        stall = 1'b0;
      end
    join
    for (i = 0; i < 9; i++) begin
      pull(gl, gr);
      chk("fifo_order", sc((i < 8) ? i * 4096 : 32768, 0.9), gl, 8);
    end
    slow = 1'b0;
    mute = 1'b1;
    repeat (48) xf(65536, 65536);
    chk("mute_step", 1, {12'h000, mlev}, 0);
    repeat (1000) xf(65536, 65536);
    chk("mute_full", 32, {12'h000, mlev}, 0);
    chk("mute_out", 0, gl, 0);
    mute = 1'b0;
    repeat (1048) xf(65536, 65536);
    chk("unmute_lvl", 0, {12'h000, mlev}, 0);
    chk("unmute_out", sc(65536, 0.9), gl, 8);
    run = 1'b1;
    ds = 1'b1;
    vol = 8'h00;
    xf(65536, 65536);
    chk("ds_vol", 0, {10'h000, appv}, 0);
    xf(65536, 65536);
    chk("ds_silence", 0, gl, 0);
    chk("ds_busy", 0, {17'h0_0000, busy}, 0);
    vol = 8'hFF;
    xf(65536, 65536);
    xf(65536, 65536);
    chk("ds_top", sc(65536, 0.9), gl, 8);
    ds = 1'b0;
    xf(16384, 16384);
    chk("ns_top", sc(16384, 0.9 * 10.0 ** (6.02 / 20.0)), gl, 40);
    run = 1'b0;
    vol = 8'hEF;
    ft = 4'h1;
    repeat (10) xf(4096, 4096);
    chk("frozen_vol", 255, {10'h000, appv}, 0);
    chk("frozen_busy", 0, {17'h0_0000, busy}, 0);
    fade(8'hEF, 1000, n);
    chk("fade_small_len", 4 * 34, n[17:0], 2);
    chk("fade_small_vol", 239, {10'h000, appv}, 0);
    fade(8'h01, 1000, n);
    chk("fade_big_len", 4 * 34, n[17:0], 2);
    chk("fade_big_vol", 1, {10'h000, appv}, 0);
    br = 4'h0;
    xf(131071, 131071);
    chk("clip_l", sc(131071, 0.9 * 10.0 ** (-89.55 / 20.0)), gl, 2);
    chk("clip_r", sc(131071, 0.9 * 10.0 ** (-89.55 / 20.0)), gr, 2);
    br = 4'hF;
    ft = 4'h0;
    fade(8'hEF, 2, n);
    fade(8'hC8, 100, n);
    chk("retarget_len", 4, n[17:0], 1);
    chk("retarget_vol", 200, {10'h000, appv}, 0);
    end_of_test();
  end
endmodule
